// ==== rtl/scc_params.svh ====
// Register map, field positions, reset values and timing counts of the sideband control block
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

`define SCC_ADDR_CTRL        8'h03
`define SCC_ADDR_LINK_STAT   8'h0c
`define SCC_ADDR_GPIO0_CFG   8'h0d
`define SCC_ADDR_GPIO21_CFG  8'h0e
`define SCC_ADDR_GPIO3_CFG   8'h0f
`define SCC_ADDR_IRQ_CTRL    8'hc6
`define SCC_ADDR_IRQ_STAT    8'hc7

`define SCC_CTRL_FILT_BIT    4
`define SCC_LINK_DET_BIT     0
`define SCC_IRQ_GLOBAL_BIT   0
`define SCC_IRQ_LINK_BIT     1
`define SCC_IRQ_REMOTE_BIT   5

`define SCC_CTRL_RESET       8'h10
`define SCC_GPIO_CFG_RESET   8'h00
`define SCC_IRQ_CTRL_RESET   8'h00

`define SCC_GPIO_FWD_CODE    4'h3
`define SCC_GPIO_BACK_CODE   4'h5
`define SCC_GPIO3_FWD_CODE   4'h5
`define SCC_GPIO3_BACK_CODE  4'h3

`define SCC_FILT_MIN_PCLK    3
`define SCC_BC_SPF_NORMAL    4'h1
`define SCC_BC_SPF_FAST4     4'h6
`define SCC_BC_SPF_FAST2     4'ha
`define SCC_BC_SPF_FAST1     4'hf

`endif

// ==== rtl/scc_pkg.sv ====
// Types shared by the sideband control block
package scc_pkg;

	typedef enum logic [2:0] {
		SCC_BC_NORMAL = 3'h0,
		SCC_BC_FAST1  = 3'h1,
		SCC_BC_FAST2  = 3'h2,
		SCC_BC_FAST4  = 3'h3
	} scc_bc_mode_e;

	typedef enum logic [1:0] {
		SCC_RATE_5M  = 2'h0,
		SCC_RATE_10M = 2'h1,
		SCC_RATE_20M = 2'h2
	} scc_bc_rate_e;

endpackage

// ==== rtl/scc_pulse_filter.sv ====
// Minimum pulse width filter for one video control bit
`timescale 1ns/10ps
`default_nettype none
`include "scc_params.svh"

module scc_pulse_filter #(
	parameter int MIN_W = `SCC_FILT_MIN_PCLK
) (
	// Clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	// Control
	input  wire logic i_en,
	// Data
	input  wire logic i_in,
	output var  logic o_out
);

	localparam int CW = $clog2(MIN_W + 1);

	logic [CW-1:0] cnt_r;
	logic          out_r;
	wire           differs = (i_in != out_r);
	wire           held    = (cnt_r == CW'(MIN_W - 1));

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r <= '0;
			out_r <= 1'b0;
		end else if (!i_en) begin
			cnt_r <= '0;
			out_r <= i_in;
		end else if (!differs) begin
			cnt_r <= '0;
		end else if (held) begin
			cnt_r <= '0;
			out_r <= i_in;
		end else begin
			cnt_r <= cnt_r + CW'(1);
		end
	end

	assign o_out = out_r;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	property p_filt_min_width;
		(MIN_W == 3) && $changed(o_out) && $past(i_en, 1) && $past(i_en, 2) && $past(i_en, 3)
			|-> $past(i_in, 1) == o_out && $past(i_in, 2) == o_out && $past(i_in, 3) == o_out;
	endproperty
	a_filt_min_width: assert property (p_filt_min_width) else $error("Filter passed a short pulse");

	property p_filt_bypass;
		!i_en |=> o_out == $past(i_in);
	endproperty
	a_filt_bypass: assert property (p_filt_bypass) else $error("Unfiltered bit did not follow input");

	property p_filt_hold;
		i_en && (i_in != o_out) ##1 (i_en && i_in == o_out) |=> $stable(o_out);
	endproperty
	a_filt_hold: assert property (p_filt_hold) else $error("Filter output moved on a glitch");

	c_filt_reject: cover property (i_en && i_in != o_out ##1 i_en && i_in == o_out);

endmodule // scc_pulse_filter

`default_nettype wire

// ==== rtl/scc_sideband.sv ====
// Sideband control of the video serializer: filters, power-down, link status, interrupts, link GPIOs
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "scc_params.svh"

module scc_sideband #(
	parameter logic [3:0] GPIO3_FWD_CODE  = `SCC_GPIO3_FWD_CODE,
	parameter logic [3:0] GPIO3_BACK_CODE = `SCC_GPIO3_BACK_CODE,
	parameter int         FILT_MIN_PCLK   = `SCC_FILT_MIN_PCLK
) (
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rst,
	// Register port
	input  wire logic [7:0] i_reg_addr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	output var  logic [7:0] o_reg_rdata,
	// Video control bits, pixel clock domain
	input  wire logic       i_horiz_sync,
	input  wire logic       i_vert_sync,
	input  wire logic       i_pixel_valid,
	output var  logic       o_horiz_sync,
	output var  logic       o_vert_sync,
	output var  logic       o_pixel_valid,
	// Power and link pins
	input  wire logic       i_power_down_n,
	input  wire logic       i_link_up,
	input  wire logic       i_link_fault,
	output var  logic       o_powered_down,
	// Interrupts
	input  wire logic       i_remote_irq_in_n,
	output var  logic       o_irq_out_n,
	output var  logic       o_remote_irq_mirror_n,
	// Back channel decoder
	input  wire logic [2:0] i_ctrl_channel_mode,
	input  wire logic       i_backchan_high_rate,
	input  wire logic       i_backchan_rate_sel,
	input  wire logic       i_bc_frame_start,
	input  wire logic       i_bc_sample,
	input  wire logic [3:0] i_bc_gpio,
	// Link GPIO pins and forward channel
	input  wire logic [3:0] i_gpio_in,
	output var  logic [3:0] o_gpio_out,
	output var  logic [3:0] o_gpio_oe,
	output var  logic [3:0] o_fwd_gpio
);

	// Pin synchroniser: {power_down_n, link_up, link_fault, gpio[3:0]}
	logic [6:0] pin_meta_r;
	logic [6:0] pin_sync_r;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_meta_r <= 7'h00;
			pin_sync_r <= 7'h00;
		end else begin
			pin_meta_r <= {i_power_down_n, i_link_up, i_link_fault, i_gpio_in};
			pin_sync_r <= pin_meta_r;
		end
	end

	wire       pdn_n_s   = pin_sync_r[6];
	wire       link_up_s = pin_sync_r[5];
	wire       fault_s   = pin_sync_r[4];
	wire [3:0] gpio_in_s = pin_sync_r[3:0];
	// Any fault kind collapses onto one bit
	wire       link_ok   = link_up_s && !fault_s;

	// Registers
	logic [7:0] ctrl_r;
	logic [7:0] gpio0_cfg_r;
	logic [7:0] gpio21_cfg_r;
	logic [7:0] gpio3_cfg_r;
	logic [7:0] irq_ctrl_r;
	logic       stat_link_r;
	logic       stat_remote_r;
	logic       link_ok_q_r;
	logic       rem_q_r;

	wire wr_ctrl   = i_reg_wr && (i_reg_addr == `SCC_ADDR_CTRL);
	wire wr_gpio0  = i_reg_wr && (i_reg_addr == `SCC_ADDR_GPIO0_CFG);
	wire wr_gpio21 = i_reg_wr && (i_reg_addr == `SCC_ADDR_GPIO21_CFG);
	wire wr_gpio3  = i_reg_wr && (i_reg_addr == `SCC_ADDR_GPIO3_CFG);
	wire wr_irq    = i_reg_wr && (i_reg_addr == `SCC_ADDR_IRQ_CTRL);
	wire rd_stat   = i_reg_rd && (i_reg_addr == `SCC_ADDR_IRQ_STAT);

	// Events; the set term wins over a same-cycle clear by read
	wire rem_fall  = rem_q_r && !i_remote_irq_in_n && link_ok;
	wire link_lost = link_ok_q_r && !link_ok;

	wire irq_glb   = irq_ctrl_r[`SCC_IRQ_GLOBAL_BIT];
	wire irq_any   = irq_glb && ((stat_remote_r && irq_ctrl_r[`SCC_IRQ_REMOTE_BIT]) ||
	                             (stat_link_r && irq_ctrl_r[`SCC_IRQ_LINK_BIT]));

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_r       <= `SCC_CTRL_RESET;
			gpio0_cfg_r  <= `SCC_GPIO_CFG_RESET;
			gpio21_cfg_r <= `SCC_GPIO_CFG_RESET;
			gpio3_cfg_r  <= `SCC_GPIO_CFG_RESET;
			irq_ctrl_r   <= `SCC_IRQ_CTRL_RESET;
		end else if (!pdn_n_s) begin
			ctrl_r       <= `SCC_CTRL_RESET;
			gpio0_cfg_r  <= `SCC_GPIO_CFG_RESET;
			gpio21_cfg_r <= `SCC_GPIO_CFG_RESET;
			gpio3_cfg_r  <= `SCC_GPIO_CFG_RESET;
			irq_ctrl_r   <= `SCC_IRQ_CTRL_RESET;
		end else begin
			if (wr_ctrl)   ctrl_r       <= i_reg_wdata;
			if (wr_gpio0)  gpio0_cfg_r  <= i_reg_wdata;
			if (wr_gpio21) gpio21_cfg_r <= i_reg_wdata;
			if (wr_gpio3)  gpio3_cfg_r  <= i_reg_wdata;
			if (wr_irq)    irq_ctrl_r   <= i_reg_wdata;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			stat_link_r   <= 1'b0;
			stat_remote_r <= 1'b0;
			link_ok_q_r   <= 1'b0;
			rem_q_r       <= 1'b1;
		end else begin
			link_ok_q_r   <= link_ok;
			rem_q_r       <= i_remote_irq_in_n;
			if (!pdn_n_s) begin
				stat_link_r   <= 1'b0;
				stat_remote_r <= 1'b0;
			end else begin
				stat_link_r   <= link_lost || (stat_link_r && !rd_stat);
				stat_remote_r <= rem_fall || (stat_remote_r && !rd_stat);
			end
		end
	end

	// Back channel mode decode
	scc_pkg::scc_bc_mode_e bc_mode;
	scc_pkg::scc_bc_rate_e bc_rate;
	logic [3:0]            spf;
	logic [2:0]            n_lanes;

	assign bc_mode = scc_pkg::scc_bc_mode_e'(i_ctrl_channel_mode);
	assign bc_rate = i_backchan_high_rate ? scc_pkg::SCC_RATE_20M :
	                 (i_backchan_rate_sel ? scc_pkg::SCC_RATE_10M : scc_pkg::SCC_RATE_5M);

	always_comb begin
		case (bc_mode)
			scc_pkg::SCC_BC_NORMAL: begin
				spf     = `SCC_BC_SPF_NORMAL;
				n_lanes = 3'h4;
			end
			scc_pkg::SCC_BC_FAST4: begin
				spf     = `SCC_BC_SPF_FAST4;
				n_lanes = 3'h4;
			end
			scc_pkg::SCC_BC_FAST2: begin
				spf     = `SCC_BC_SPF_FAST2;
				n_lanes = 3'h2;
			end
			scc_pkg::SCC_BC_FAST1: begin
				spf     = `SCC_BC_SPF_FAST1;
				n_lanes = 3'h1;
			end
			default: begin
				// SPI and reserved modes carry no back-channel GPIO
				spf     = 4'h0;
				n_lanes = 3'h0;
			end
		endcase
	end

	// Samples past the mode's per-frame count are dropped
	logic [3:0] smp_cnt_r;
	wire  [3:0] smp_base = i_bc_frame_start ? 4'h0 : smp_cnt_r;
	wire        bc_take  = i_bc_sample && link_ok && (smp_base < spf);

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			smp_cnt_r <= 4'h0;
		end else begin
			smp_cnt_r <= smp_base + {3'h0, bc_take};
		end
	end

	// Per-lane GPIO configuration
	logic [3:0][3:0] lane_cfg;
	logic [3:0]      lane_fwd;
	logic [3:0]      lane_back;
	logic [3:0]      bc_val_r;
	logic [3:0]      gpio_out_r;
	logic [3:0]      gpio_oe_r;
	logic [3:0]      fwd_gpio_r;

	assign lane_cfg = {gpio3_cfg_r[3:0], gpio21_cfg_r[7:4], gpio21_cfg_r[3:0], gpio0_cfg_r[3:0]};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			wire [3:0] fwd_code  = (g == 3) ? GPIO3_FWD_CODE  : `SCC_GPIO_FWD_CODE;
			wire [3:0] back_code = (g == 3) ? GPIO3_BACK_CODE : `SCC_GPIO_BACK_CODE;
			wire       lane_ok   = (3'(g) < n_lanes);
			assign lane_fwd[g]  = (lane_cfg[g] == fwd_code);
			assign lane_back[g] = (lane_cfg[g] == back_code);

			always_ff @(posedge i_core_clk or posedge i_rst) begin
				if (i_rst) begin
					bc_val_r[g]   <= 1'b0;
					gpio_out_r[g] <= 1'b0;
					gpio_oe_r[g]  <= 1'b0;
					fwd_gpio_r[g] <= 1'b0;
				end else begin
					if (bc_take && lane_ok) bc_val_r[g] <= i_bc_gpio[g];
					gpio_out_r[g] <= bc_val_r[g];
					gpio_oe_r[g]  <= lane_back[g] && pdn_n_s;
					fwd_gpio_r[g] <= lane_fwd[g] && gpio_in_s[g];
				end
			end
		end
	endgenerate

	// Video control filters; vertical sync is slow by contract and passes through
	logic vs_r;

	scc_pulse_filter #(
		.MIN_W(FILT_MIN_PCLK)
	) u_filt_hsync (
		.i_core_clk(i_core_clk),
		.i_rst     (i_rst),
		.i_en      (ctrl_r[`SCC_CTRL_FILT_BIT]),
		.i_in      (i_horiz_sync),
		.o_out     (o_horiz_sync)
	);

	scc_pulse_filter #(
		.MIN_W(FILT_MIN_PCLK)
	) u_filt_valid (
		.i_core_clk(i_core_clk),
		.i_rst     (i_rst),
		.i_en      (ctrl_r[`SCC_CTRL_FILT_BIT]),
		.i_in      (i_pixel_valid),
		.o_out     (o_pixel_valid)
	);

	// Outputs and read port
	logic       irq_n_r;
	logic       mirror_n_r;
	logic       pd_r;
	logic [7:0] rdata_r;
	logic [7:0] rd_mux;

	wire [7:0] link_stat_val = {1'b0, i_ctrl_channel_mode, 1'b0, bc_rate, link_ok};
	wire [7:0] irq_stat_val  = {2'h0, stat_remote_r, 3'h0, stat_link_r, irq_any};

	assign rd_mux = (i_reg_addr == `SCC_ADDR_CTRL)       ? ctrl_r :
	                (i_reg_addr == `SCC_ADDR_LINK_STAT)  ? link_stat_val :
	                (i_reg_addr == `SCC_ADDR_GPIO0_CFG)  ? gpio0_cfg_r :
	                (i_reg_addr == `SCC_ADDR_GPIO21_CFG) ? gpio21_cfg_r :
	                (i_reg_addr == `SCC_ADDR_GPIO3_CFG)  ? gpio3_cfg_r :
	                (i_reg_addr == `SCC_ADDR_IRQ_CTRL)   ? irq_ctrl_r :
	                (i_reg_addr == `SCC_ADDR_IRQ_STAT)   ? irq_stat_val : 8'h00;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_n_r    <= 1'b1;
			mirror_n_r <= 1'b1;
			pd_r       <= 1'b1;
			vs_r       <= 1'b0;
			rdata_r    <= 8'h00;
		end else begin
			irq_n_r    <= !irq_any;
			mirror_n_r <= link_ok ? i_remote_irq_in_n : 1'b1;
			pd_r       <= !pdn_n_s;
			vs_r       <= i_vert_sync;
			rdata_r    <= i_reg_rd ? rd_mux : 8'h00;
		end
	end

	assign o_irq_out_n           = irq_n_r;
	assign o_remote_irq_mirror_n = mirror_n_r;
	assign o_powered_down        = pd_r;
	assign o_vert_sync           = vs_r;
	assign o_reg_rdata           = rdata_r;
	assign o_gpio_out            = gpio_out_r;
	assign o_gpio_oe             = gpio_oe_r;
	assign o_fwd_gpio            = fwd_gpio_r;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	property p_pdn_defaults;
		!pdn_n_s |=> ctrl_r == `SCC_CTRL_RESET && irq_ctrl_r == `SCC_IRQ_CTRL_RESET && !stat_remote_r;
	endproperty
	a_pdn_defaults: assert property (p_pdn_defaults) else $error("Registers not default in power-down");

	property p_link_read;
		i_reg_rd && i_reg_addr == `SCC_ADDR_LINK_STAT |=> o_reg_rdata[0] == $past(link_up_s && !fault_s);
	endproperty
	a_link_read: assert property (p_link_read) else $error("Link status read wrong");

	property p_irq_pin;
		rem_fall && pdn_n_s && irq_ctrl_r[0] && irq_ctrl_r[5] && !wr_irq |=> ##1 !o_irq_out_n;
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("Remote interrupt did not pull output low");

	property p_read_clears;
		rd_stat && !rem_fall && !link_lost |=> !stat_remote_r && !stat_link_r ##1 o_irq_out_n;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("Status read did not release interrupt");

	property p_remote_edge;
		$rose(stat_remote_r) |-> $past(rem_q_r) && !$past(i_remote_irq_in_n);
	endproperty
	a_remote_edge: assert property (p_remote_edge) else $error("Remote interrupt set without falling edge");

	property p_mirror;
		!link_ok |=> o_remote_irq_mirror_n;
	endproperty
	a_mirror: assert property (p_mirror) else $error("Remote mirror low without link");

	property p_sample_limit;
		bc_take |-> smp_base < ((i_ctrl_channel_mode == 3'h3) ? 4'h6 : (i_ctrl_channel_mode == 3'h2) ? 4'ha :
		                        (i_ctrl_channel_mode == 3'h1) ? 4'hf : (i_ctrl_channel_mode == 3'h0) ? 4'h1 : 4'h0);
	endproperty
	a_sample_limit: assert property (p_sample_limit) else $error("Back-channel sample over frame limit");

	c_remote_irq: cover property (rem_fall ##[1:20] rd_stat);
	c_fast1_full: cover property (bc_mode == scc_pkg::SCC_BC_FAST1 && smp_cnt_r == 4'hf);
	c_link_loss:  cover property (link_lost ##1 !o_irq_out_n);

endmodule // scc_sideband

`default_nettype wire

// ==== verification/scc_deser_model.sv ====
// Behavioural companion deserializer: back-channel frames and rate select
`timescale 1ns/10ps
`default_nettype none

module scc_deser_model (
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rst,
	// Bench control
	input  wire logic       i_send,
	input  wire logic [3:0] i_seed,
	input  wire logic [1:0] i_rate,
	// Back channel toward the serializer
	output var  logic       o_frame_start,
	output var  logic       o_sample,
	output var  logic [3:0] o_bc_gpio,
	output var  logic       o_high_rate,
	output var  logic       o_rate_sel
);
	logic [4:0] k_r;
	logic       busy_r;

	// Rate code 0/1/2 picks 5, 10 or 20 Mbps
	assign o_high_rate = (i_rate == 2'h2);
	assign o_rate_sel  = (i_rate == 2'h1);

	// Sixteen samples a frame, more than any mode accepts
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			k_r           <= 5'h00;
			busy_r        <= 1'b0;
			o_frame_start <= 1'b0;
			o_sample      <= 1'b0;
			o_bc_gpio     <= 4'h0;
		end else if (i_send && !busy_r) begin
			o_frame_start <= 1'b1;
			o_sample      <= 1'b1;
			o_bc_gpio     <= i_seed;
			k_r           <= 5'h01;
			busy_r        <= 1'b1;
		end else if (busy_r) begin
			o_frame_start <= 1'b0;
			o_sample      <= 1'b1;
			o_bc_gpio     <= k_r[3:0] ^ i_seed;
			k_r           <= k_r + 5'h01;
			busy_r        <= (k_r != 5'h0f);
		end else begin
			// Stale data must not look like a valid sample
			o_frame_start <= 1'b0;
			o_sample      <= 1'b0;
			o_bc_gpio     <= ~o_bc_gpio;
		end
	end
endmodule // scc_deser_model
`default_nettype wire

// ==== verification/scc_sideband_test.sv ====
// Self-checking bench of the sideband control block
`timescale 1ns/10ps
`default_nettype none
`include "scc_params.svh"

module scc_sideband_test;
	logic        clk, rst, wr, rd, hs, vs, pv, pdn, lnk, flt, irq_n, send;
	logic        ohs, ovs, opv, pdo, irqo, mir, hr, rs, fs, smp;
	logic [7:0]  addr, wdata, rdata, d;
	logic [3:0]  gin, gout, goe, fwd, seed, bcg, ex;
	logic [2:0]  mode;
	logic [1:0]  rate;
	logic [31:0] rnd;
	int          miscompares, n_tests, cnt;

	scc_sideband DUT (.i_core_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_horiz_sync(hs), .i_vert_sync(vs),
		.i_pixel_valid(pv), .o_horiz_sync(ohs), .o_vert_sync(ovs), .o_pixel_valid(opv),
		.i_power_down_n(pdn), .i_link_up(lnk), .i_link_fault(flt), .o_powered_down(pdo),
		.i_remote_irq_in_n(irq_n), .o_irq_out_n(irqo), .o_remote_irq_mirror_n(mir),
		.i_ctrl_channel_mode(mode), .i_backchan_high_rate(hr), .i_backchan_rate_sel(rs),
		.i_bc_frame_start(fs), .i_bc_sample(smp), .i_bc_gpio(bcg), .i_gpio_in(gin),
		.o_gpio_out(gout), .o_gpio_oe(goe), .o_fwd_gpio(fwd));

	scc_deser_model u_deser (.i_core_clk(clk), .i_rst(rst), .i_send(send), .i_seed(seed),
		.i_rate(rate), .o_frame_start(fs), .o_sample(smp), .o_bc_gpio(bcg),
		.o_high_rate(hr), .o_rate_sel(rs));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Last accepted sample per lane; lanes outside the mode keep their value
	function automatic logic [3:0] bc_exp(input logic [3:0] prev, sd, input int m);
		int         n[4] = '{1, 6, 10, 15};
		int         lanes[4] = '{4, 4, 2, 1};
		logic [3:0] v;
		v = 4'(n[m] - 1) ^ sd;
		for (int l = 0; l < 4; l++)
			if (l < lanes[m])
				prev[l] = v[l];
		return prev;
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input logic [7:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask

	// Pulses spaced 140 clocks apart keep the source limits
	task automatic pulse(input int len, output int hi);
		hi = 0;
		for (int i = 0; i < 140; i++) begin
			@(posedge clk);
			hs <= (i < len);
			pv <= (i < len);
			vs <= (i == 0) ? ~vs : vs;
			#1 hi += int'(ohs === 1'b1 && opv === 1'b1);
			if (i < 2) chk(8'(ovs), 8'(vs ^ (i == 0)));
		end
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge clk);
		miscompares++;
		conclude();
	end

	initial begin
		{rst, wr, rd, hs, vs, pv, flt, send} = 8'hff;
		{wr, rd, hs, vs, pv, flt, send} = 7'h00;
		{pdn, lnk, irq_n} = 3'h7;
		{addr, wdata, gin, seed, mode, rate} = 29'h0;
		rnd = 32'h2ab7f972;
		miscompares = 0;
		n_tests = 0;
		tick(3);
		rst <= 1'b0;
		tick(4);
		rd_reg(8'h03, d);
		chk(d, `SCC_CTRL_RESET);
		rd_reg(8'h55, d);
		chk(d, 8'h00);
		$display("test defaults done");

		for (int f = 1; f >= 0; f--) begin
			if (f == 0)
				wr_reg(8'h03, 8'h00);
			for (int len = 1; len <= 3; len++) begin
				pulse(len, cnt);
				chk(8'(cnt), 8'((f == 0 || len >= 3) ? len : 0));
			end
		end
		$display("test filter done");

		rd_reg(8'h0c, d);
		chk(8'(d[0]), 8'h01);
		tick(1);
		flt <= 1'b1;
		tick(4);
		rd_reg(8'h0c, d);
		chk(8'(d[0]), 8'h00);
		tick(1);
		flt <= 1'b0;
		tick(4);
		rd_reg(8'hc7, d);
		$display("test link status done");

		wr_reg(8'hc6, 8'h21);
		irq_n <= 1'b0;
		cnt = 0;
		while (irqo !== 1'b0 && cnt < 8) begin
			tick(1);
			#1 cnt++;
		end
		chk(8'(irqo), 8'h00);
		chk(8'(mir), 8'h00);
		rd_reg(8'hc7, d);
		chk(8'(d[5]), 8'h01);
		tick(1);
		#1 chk(8'(irqo), 8'h01);
		tick(10);
		#1 chk(8'(irqo), 8'h01);
		tick(1);
		irq_n <= 1'b1;
		tick(3);
		#1 chk(8'(mir), 8'h01);
		tick(1);
		irq_n <= 1'b0;
		tick(4);
		#1 chk(8'(irqo), 8'h00);
		rd_reg(8'hc7, d);
		tick(1);
		lnk <= 1'b0;
		tick(5);
		#1 chk(8'(mir), 8'h01);
		tick(1);
		lnk <= 1'b1;
		irq_n <= 1'b1;
		tick(5);
		rd_reg(8'hc7, d);
		$display("test interrupts done");

		wr_reg(8'h0d, 8'h03);
		wr_reg(8'h0e, 8'h33);
		wr_reg(8'h0f, 8'(`SCC_GPIO3_FWD_CODE));
		repeat (6) begin
			rnd = lfsr(rnd);
			tick(1);
			gin <= rnd[3:0];
			tick(4);
			#1 chk(8'(fwd), 8'(rnd[3:0]));
			chk(8'(goe), 8'h00);
		end
		wr_reg(8'h0d, 8'h05);
		wr_reg(8'h0e, 8'h55);
		wr_reg(8'h0f, 8'(`SCC_GPIO3_BACK_CODE));
		tick(3);
		#1 chk(8'(goe), 8'h0f);
		ex = 4'h0;
		for (int m = 0; m < 4; m++) begin
			rnd = lfsr(rnd);
			tick(1);
			mode <= (m == 0) ? 3'h0 : 3'(4 - m);
			rate <= 2'(m % 3);
			seed <= rnd[3:0];
			tick(1);
			send <= 1'b1;
			tick(1);
			send <= 1'b0;
			tick(25);
			ex = bc_exp(ex, seed, m);
			#1 chk(8'(gout), 8'(ex));
			rd_reg(8'h0c, d);
			chk(d, {1'b0, mode, 1'b0, rate, 1'b1});
		end
		// A mode with no back-channel GPIO must leave the pins alone
		tick(1);
		mode <= 3'h6;
		seed <= ~seed;
		tick(1);
		send <= 1'b1;
		tick(1);
		send <= 1'b0;
		tick(25);
		#1 chk(8'(gout), 8'(ex));
		$display("test gpio done");

		wr_reg(8'h03, 8'h00);
		pdn <= 1'b0;
		tick(75000);
		#1 chk(8'(pdo), 8'h01);
		tick(1);
		pdn <= 1'b1;
		tick(4);
		rd_reg(8'h03, d);
		chk(d, `SCC_CTRL_RESET);
		rd_reg(8'h0e, d);
		chk(d, `SCC_GPIO_CFG_RESET);
		rd_reg(8'hc6, d);
		chk(d, `SCC_IRQ_CTRL_RESET);
		chk(8'(goe), 8'h00);
		$display("test power down done");
		conclude();
	end
endmodule // scc_sideband_test
`default_nettype wire
